// [core/ptme_params.svh]
// constants for the status-transfer and multiply execute block
`ifndef PTME_PARAMS_SVH
`define PTME_PARAMS_SVH
`define PTME_CLK_MHZ 25
`define PTME_OP_HI_VAL 5'h02
`define PTME_RD_MID_VAL 6'h0F
`define PTME_WR_MID_VAL 10'h29F
`define PTME_FLG_HI_VAL 2'h0
`define PTME_FLG_MID_VAL 2'h2
`define PTME_MUL_HI_VAL 6'h00
`define PTME_MUL_LO_VAL 4'h9
`define PTME_SEL_BIT 22
`define PTME_IMM_BIT 25
`define PTME_ACC_BIT 21
`define PTME_SET_BIT 20
`define PTME_MODE_USER 5'h10
`define PTME_MODE_RESET 5'h13
`define PTME_STATUS_RESET 32'h0000_00D3
`define PTME_IMPL_MASK 32'hF000_00DF
`define PTME_FLAG_MASK 32'hF000_0000
`define PTME_MAX_ITER 5'h10
`define PTME_NUM_BANKS 5
`endif

// [core/ptme_pkg.sv]
// types for the status-transfer and multiply execute block
package ptme_pkg;
  typedef enum logic [1:0] {
    PTME_IDLE = 2'b00,
    PTME_XFER = 2'b01,
    PTME_MULT = 2'b11,
    PTME_DONE = 2'b10
  } ptme_state_t;

  typedef struct packed {
    logic [3:0] rd;
    logic [3:0] rn;
    logic [3:0] rs;
    logic [3:0] rm;
  } ptme_regsel_t;

  typedef struct packed {
    logic we;
    logic [3:0] idx;
    logic [31:0] data;
  } ptme_wr_t;
endpackage

// [core/ptme_exec.sv]
// execute logic for status transfers and multiply / multiply-accumulate
`timescale 1ns/100ps
`default_nettype none
`include "ptme_params.svh"

// What this block does
// - execute only when condition passes
// - decode status-to-register read fields
// - decode full register-to-status write fields
// - decode flags-only status write fields
// - select bit picks current or banked saved
// - flags-only write copies bits 31:28
// - user mode current write touches flags only
// - privileged full write replaces whole word
// - immediate-select bit picks immediate or register
// - only eleven status bits are implemented
// - status transfer takes one cycle
// - status read copies whole word
// - compare opcodes without set bit transfer status
// - 2-bit Booth multiply, low 32 bits
// - plain multiply ignores accumulate register
// - accumulate form adds accumulate register
// - destination equal to first operand is unsafe
// - set bit updates negative and zero
// - m internal cycles from multiplier magnitude
// - multiplier 0/1 one cycle, max sixteen
// - immediate is rotated eight-bit field
module ptme_exec
  import ptme_pkg::*;
#(
  parameter int XLEN = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // instruction issue
  input wire logic issue_valid,
  input wire logic [31:0] instr,
  output logic issue_ready,
  // register file read operands (combinational, indexed by regsel)
  output ptme_regsel_t regsel,
  input wire logic [XLEN-1:0] first_operand_value,
  input wire logic [XLEN-1:0] multiplier_value,
  input wire logic [XLEN-1:0] accumulate_value,
  // register file write
  output ptme_wr_t rf_wr,
  // status words
  output logic [31:0] current_status_word,
  output logic [31:0] saved_status_word,
  // completion
  output logic done,
  output logic unclaimed
);
  logic [31:0] current_status_word_ff, nxt_current_status_word;
  logic [31:0] saved_status_word_ff [`PTME_NUM_BANKS], nxt_saved_status_word [`PTME_NUM_BANKS];
  ptme_state_t st_ff, nxt_st;
  logic [31:0] acc_ff, nxt_acc;
  logic [31:0] mcand_ff, nxt_mcand;
  logic [31:0] mplier_ff, nxt_mplier;
  logic carry_ff, nxt_carry;
  logic [4:0] iter_ff, nxt_iter;
  logic [4:0] need_ff, nxt_need;
  logic [3:0] rd_ff, nxt_rd;
  logic set_ff, nxt_set;
  ptme_wr_t wr_ff, nxt_wr;
  logic done_ff, nxt_done;
  logic unc_ff, nxt_unc;

  // condition field evaluation against current flags
  logic n_f, z_f, c_f, v_f, cond_ok;
  assign n_f = current_status_word_ff[31];
  assign z_f = current_status_word_ff[30];
  assign c_f = current_status_word_ff[29];
  assign v_f = current_status_word_ff[28];
  always_comb begin
    unique case (instr[31:28])
      4'h0: cond_ok = z_f;
      4'h1: cond_ok = !z_f;
      4'h2: cond_ok = c_f;
      4'h3: cond_ok = !c_f;
      4'h4: cond_ok = n_f;
      4'h5: cond_ok = !n_f;
      4'h6: cond_ok = v_f;
      4'h7: cond_ok = !v_f;
      4'h8: cond_ok = c_f && !z_f;
      4'h9: cond_ok = !c_f || z_f;
      4'hA: cond_ok = n_f == v_f;
      4'hB: cond_ok = n_f != v_f;
      4'hC: cond_ok = !z_f && (n_f == v_f);
      4'hD: cond_ok = z_f || (n_f != v_f);
      4'hE: cond_ok = 1'b1;
      4'hF: cond_ok = 1'b0;
    endcase
  end

  // decode; the status transfers occupy compare/test opcodes with set bit clear
  logic is_rd, is_wr, is_flg, is_mul;
  assign is_rd = instr[27:23] == `PTME_OP_HI_VAL && instr[21:16] == `PTME_RD_MID_VAL
    && instr[11:0] == 12'h000;
  assign is_wr = instr[27:23] == `PTME_OP_HI_VAL && instr[21:12] == `PTME_WR_MID_VAL
    && instr[11:4] == 8'h00;
  assign is_flg = instr[27:26] == `PTME_FLG_HI_VAL && instr[24:23] == `PTME_FLG_MID_VAL
    && instr[21:12] == `PTME_WR_MID_VAL && !is_wr;
  assign is_mul = instr[27:22] == `PTME_MUL_HI_VAL && instr[7:4] == `PTME_MUL_LO_VAL;

  // saved word bank per mode; user/system have none
  function automatic logic [2:0] bank_of(input logic [4:0] m);
    unique case (m)
      5'h11: bank_of = 3'h0;
      5'h12: bank_of = 3'h1;
      5'h13: bank_of = 3'h2;
      5'h17: bank_of = 3'h3;
      5'h1B: bank_of = 3'h4;
      default: bank_of = 3'h7;
    endcase
  endfunction

  logic [2:0] bank;
  logic bank_ok, user_mode;
  assign bank = bank_of(current_status_word_ff[4:0]);
  assign bank_ok = bank != 3'h7;
  assign user_mode = current_status_word_ff[4:0] == `PTME_MODE_USER;

  // immediate source: zero-extended byte rotated right by twice the field
  logic [31:0] imm_val, src_val;
  logic [4:0] rot;
  assign rot = {instr[11:8], 1'b0};
  assign imm_val = ({24'h00_0000, instr[7:0]} >> rot) | ({24'h00_0000, instr[7:0]} << (6'd32 - {1'b0, rot}));
  assign src_val = instr[`PTME_IMM_BIT] ? imm_val : first_operand_value;

  assign regsel.rd = instr[15:12];
  assign regsel.rn = is_mul ? instr[15:12] : instr[19:16];
  assign regsel.rs = instr[11:8];
  assign regsel.rm = instr[3:0];

  // required Booth iterations from multiplier magnitude: m = ceil((msb+2)/2)
  function automatic logic [4:0] iters_of(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h01;
    for (int k = 1; k < 32; k++) begin
      if (v[k]) r = 5'((k + 3) / 2);
    end
    if (r > `PTME_MAX_ITER) r = `PTME_MAX_ITER;
    return r;
  endfunction

  // 2-bit Booth step: digit from two multiplier bits plus carried bit
  logic [31:0] booth_add;
  logic booth_carry;
  always_comb begin
    booth_add = 32'h0000_0000;
    booth_carry = 1'b0;
    unique case ({mplier_ff[1:0], carry_ff})
      3'b000: begin booth_add = 32'h0000_0000; booth_carry = 1'b0; end
      3'b001: begin booth_add = mcand_ff; booth_carry = 1'b0; end
      3'b010: begin booth_add = mcand_ff; booth_carry = 1'b0; end
      3'b011: begin booth_add = mcand_ff << 1; booth_carry = 1'b0; end
      3'b100: begin booth_add = -(mcand_ff << 1); booth_carry = 1'b1; end
      3'b101: begin booth_add = -mcand_ff; booth_carry = 1'b1; end
      3'b110: begin booth_add = -mcand_ff; booth_carry = 1'b1; end
      3'b111: begin booth_add = 32'h0000_0000; booth_carry = 1'b1; end
    endcase
  end

  logic [31:0] acc_step;
  assign acc_step = acc_ff + booth_add;

  assign issue_ready = st_ff == PTME_IDLE;

  always_comb begin
    nxt_current_status_word = current_status_word_ff;
    for (int b = 0; b < `PTME_NUM_BANKS; b++) nxt_saved_status_word[b] = saved_status_word_ff[b];
    nxt_st = st_ff;
    nxt_acc = acc_ff;
    nxt_mcand = mcand_ff;
    nxt_mplier = mplier_ff;
    nxt_carry = carry_ff;
    nxt_iter = iter_ff;
    nxt_need = need_ff;
    nxt_rd = rd_ff;
    nxt_set = set_ff;
    nxt_wr = '0;
    nxt_done = 1'b0;
    nxt_unc = 1'b0;
    unique case (st_ff)
      PTME_IDLE: begin
        if (issue_valid) begin
          if (!cond_ok) begin
            nxt_done = 1'b1;
          end else if (is_rd) begin
            nxt_wr.we = 1'b1;
            nxt_wr.idx = instr[15:12];
            nxt_wr.data = instr[`PTME_SEL_BIT] ? (bank_ok ? saved_status_word_ff[bank] : 32'h0000_0000)
              : current_status_word_ff;
            nxt_done = 1'b1;
          end else if (is_wr || is_flg) begin
            if (instr[`PTME_SEL_BIT]) begin
              if (bank_ok) begin
                if (is_flg) begin
                  nxt_saved_status_word[bank] = (saved_status_word_ff[bank] & ~`PTME_FLAG_MASK) | (src_val & `PTME_FLAG_MASK);
                end else begin
                  nxt_saved_status_word[bank] = first_operand_value & `PTME_IMPL_MASK;
                end
              end
            end else if (is_flg || user_mode) begin
              nxt_current_status_word = (current_status_word_ff & ~`PTME_FLAG_MASK)
                | ((is_flg ? src_val : first_operand_value) & `PTME_FLAG_MASK);
            end else begin
              nxt_current_status_word = first_operand_value & `PTME_IMPL_MASK;
            end
            nxt_done = 1'b1;
          end else if (is_mul) begin
            // destination aliasing the first operand: a plain multiply gives zero
            nxt_mcand = (!instr[`PTME_ACC_BIT] && instr[19:16] == instr[3:0]) ? 32'h0000_0000
              : first_operand_value;
            nxt_mplier = multiplier_value;
            nxt_carry = 1'b0;
            nxt_acc = instr[`PTME_ACC_BIT] ? accumulate_value : 32'h0000_0000;
            nxt_need = iters_of(multiplier_value);
            nxt_iter = 5'h00;
            nxt_rd = instr[19:16];
            nxt_set = instr[`PTME_SET_BIT];
            nxt_st = PTME_MULT;
          end else begin
            nxt_unc = 1'b1;
            nxt_done = 1'b1;
          end
        end
      end
      PTME_MULT: begin
        nxt_acc = acc_step;
        nxt_mcand = mcand_ff << 2;
        nxt_mplier = mplier_ff >> 2;
        nxt_carry = booth_carry;
        nxt_iter = iter_ff + 5'h01;
        if (iter_ff + 5'h01 == need_ff) nxt_st = PTME_DONE;
      end
      PTME_DONE: begin
        nxt_wr.we = 1'b1;
        nxt_wr.idx = rd_ff;
        nxt_wr.data = acc_ff;
        if (set_ff) begin
          nxt_current_status_word[31] = acc_ff[31];
          nxt_current_status_word[30] = acc_ff == 32'h0000_0000;
        end
        nxt_done = 1'b1;
        nxt_st = PTME_IDLE;
      end
      PTME_XFER: nxt_st = PTME_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      current_status_word_ff <= `PTME_STATUS_RESET;
      for (int b = 0; b < `PTME_NUM_BANKS; b++) saved_status_word_ff[b] <= 32'h0000_0000;
      st_ff <= PTME_IDLE;
      acc_ff <= 32'h0000_0000;
      mcand_ff <= 32'h0000_0000;
      mplier_ff <= 32'h0000_0000;
      carry_ff <= 1'b0;
      iter_ff <= 5'h00;
      need_ff <= 5'h00;
      rd_ff <= 4'h0;
      set_ff <= 1'b0;
      wr_ff <= '0;
      done_ff <= 1'b0;
      unc_ff <= 1'b0;
    end else begin
      current_status_word_ff <= nxt_current_status_word;
      for (int b = 0; b < `PTME_NUM_BANKS; b++) saved_status_word_ff[b] <= nxt_saved_status_word[b];
      st_ff <= nxt_st;
      acc_ff <= nxt_acc;
      mcand_ff <= nxt_mcand;
      mplier_ff <= nxt_mplier;
      carry_ff <= nxt_carry;
      iter_ff <= nxt_iter;
      need_ff <= nxt_need;
      rd_ff <= nxt_rd;
      set_ff <= nxt_set;
      wr_ff <= nxt_wr;
      done_ff <= nxt_done;
      unc_ff <= nxt_unc;
    end
  end

  assign rf_wr = wr_ff;
  assign done = done_ff;
  assign unclaimed = unc_ff;
  assign current_status_word = current_status_word_ff;
  assign saved_status_word = bank_ok ? saved_status_word_ff[bank] : 32'h0000_0000;

  a_skip_cond: assert property (@(posedge clk) disable iff (srst)
    issue_ready && issue_valid && !cond_ok |=> !rf_wr.we && $stable(current_status_word_ff))
    else $error("failed condition still had an effect");
  a_xfer_one: assert property (@(posedge clk) disable iff (srst)
    issue_ready && issue_valid && cond_ok && (is_rd || is_wr || is_flg) |=> done && issue_ready)
    else $error("status transfer not done in one cycle");
  a_read_word: assert property (@(posedge clk) disable iff (srst)
    issue_ready && issue_valid && cond_ok && is_rd && !instr[22] |=> rf_wr.we && rf_wr.data == $past(current_status_word_ff))
    else $error("status read value wrong");
  a_user_prot: assert property (@(posedge clk) disable iff (srst)
    issue_ready && issue_valid && cond_ok && is_wr && !instr[22] && user_mode
    |=> current_status_word_ff[27:0] == $past(current_status_word_ff[27:0]))
    else $error("user write changed control bits");
  a_flag_only: assert property (@(posedge clk) disable iff (srst)
    issue_ready && issue_valid && cond_ok && is_flg && !instr[22]
    |=> current_status_word_ff[31:28] == $past(src_val[31:28]) && current_status_word_ff[27:0] == $past(current_status_word_ff[27:0]))
    else $error("flags-only write wrong");
  a_priv_full: assert property (@(posedge clk) disable iff (srst)
    issue_ready && issue_valid && cond_ok && is_wr && !instr[22] && !user_mode
    |=> current_status_word_ff == ($past(first_operand_value) & 32'hF000_00DF))
    else $error("privileged full write wrong");
  a_resv_zero: assert property (@(posedge clk) disable iff (srst)
    current_status_word_ff[27:8] == 20'h0_0000 && !current_status_word_ff[5])
    else $error("reserved status bits set");
  a_mul_fast: assert property (@(posedge clk) disable iff (srst)
    issue_ready && issue_valid && cond_ok && is_mul && multiplier_value < 32'h0000_0002
    |=> ##2 done && rf_wr.we)
    else $error("multiply by 0/1 not one iteration");
  a_mul_max: assert property (@(posedge clk) disable iff (srst)
    issue_ready && issue_valid && cond_ok && is_mul |=> ##[1:16] (st_ff == PTME_DONE))
    else $error("multiply exceeded sixteen iterations");
  a_mul_flags: assert property (@(posedge clk) disable iff (srst)
    st_ff == PTME_DONE && set_ff |=> current_status_word_ff[31] == rf_wr.data[31]
    && current_status_word_ff[30] == (rf_wr.data == 32'h0000_0000) && current_status_word_ff[28] == $past(current_status_word_ff[28]))
    else $error("multiply flags wrong");
endmodule
`default_nettype wire

// [dv/ptme_regfile.sv]
// register file model on the far side of the execute block
`timescale 1ns/100ps
`default_nettype none
module ptme_regfile
  import ptme_pkg::*;
(
  // clock
  input wire logic clk,
  // read indices and write port
  input wire ptme_regsel_t regsel,
  input wire ptme_wr_t rf_wr,
  // operand values
  output logic [31:0] first_operand_value,
  output logic [31:0] multiplier_value,
  output logic [31:0] accumulate_value
);
  // entry 15 is never named by the bench programs
  logic [31:0] regs [16];
  // reads are combinational: the block samples them in its issue cycle
  assign first_operand_value = regs[regsel.rm];
  assign multiplier_value = regs[regsel.rs];
  assign accumulate_value = regs[regsel.rn];
  initial begin
    for (int i = 0; i < 16; i++) begin
      regs[i] = 32'h5A5A_0000 + 32'(i);
    end
  end
  // plain always: the bench also preloads entries directly
  always @(posedge clk) begin
    if (rf_wr.we) begin
      regs[rf_wr.idx] <= rf_wr.data;
    end
  end
endmodule
`default_nettype wire

// [dv/ptme_exec_test.sv]
// self-checking bench for the status-transfer and multiply block
`timescale 1ns/100ps
`default_nettype none
module ptme_exec_test;
  import ptme_pkg::*;
  logic clk;
  logic srst;
  logic issue_valid;
  logic [31:0] instr;
  logic issue_ready;
  ptme_regsel_t regsel;
  logic [31:0] first_operand_value;
  logic [31:0] multiplier_value;
  logic [31:0] accumulate_value;
  ptme_wr_t rf_wr;
  logic [31:0] current_status_word;
  logic [31:0] saved_status_word;
  logic done;
  logic unclaimed;
  int n_mismatch = 0;
  int num_checks = 0;
  int lat;
  ptme_wr_t wr;
  logic unc;
  ptme_exec i_ptme_exec (.clk(clk), .srst(srst), .issue_valid(issue_valid), .instr(instr),
    .issue_ready(issue_ready), .regsel(regsel), .first_operand_value(first_operand_value),
    .multiplier_value(multiplier_value), .accumulate_value(accumulate_value), .rf_wr(rf_wr),
    .current_status_word(current_status_word), .saved_status_word(saved_status_word),
    .done(done), .unclaimed(unclaimed));
  ptme_regfile i_ptme_regfile (.clk(clk), .regsel(regsel), .rf_wr(rf_wr),
    .first_operand_value(first_operand_value), .multiplier_value(multiplier_value),
    .accumulate_value(accumulate_value));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic setr(input int idx, input logic [31:0] v);
    i_ptme_regfile.regs[idx] = v;
  endtask
  // offer one instruction, then count cycles from the take edge to done
  task automatic exec(input logic [31:0] ins);
    int n;
    @(posedge clk);
    issue_valid <= 1'b1;
    instr <= ins;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (issue_ready !== 1'b1 && n < 40);
    @(posedge clk);
    issue_valid <= 1'b0;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (done !== 1'b1 && lat < 40);
    wr = rf_wr;
    unc = unclaimed;
  endtask
  task automatic t_reset();
    chk("status", 32'h0000_00D3, current_status_word);
    chk("saved", 32'h0000_0000, saved_status_word);
    chk("ready", 32'h0000_0001, 32'(issue_ready));
  endtask
  task automatic t_read();
    exec(32'hE10F_1000);
    chk("latency", 32'd1, 32'(lat));
    chk("index", 32'h0000_0001, 32'(wr.idx));
    chk("data", 32'h0000_00D3, wr.data);
  endtask
  task automatic t_full();
    setr(2, 32'hF000_00D3);
    exec(32'hE129_F002);
    chk("latency", 32'd1, 32'(lat));
    chk("status", 32'hF000_00D3, current_status_word);
    setr(3, 32'h1000_0010);
    exec(32'hE169_F003);
    chk("saved", 32'h1000_0010, saved_status_word);
    chk("status", 32'hF000_00D3, current_status_word);
    exec(32'hE14F_4000);
    chk("data", 32'h1000_0010, wr.data);
  endtask
  task automatic t_flags();
    exec(32'hE329_F20A);
    chk("status", 32'hA000_00D3, current_status_word);
    exec(32'hE369_F20C);
    chk("saved", 32'hC000_0010, saved_status_word);
    setr(5, 32'h5FFF_FFFF);
    exec(32'hE129_F0F5);
    chk("status", 32'h5000_00D3, current_status_word);
  endtask
  // flags now hold zero and overflow set
  task automatic t_cond();
    exec(32'h1129_F002);
    chk("status", 32'h5000_00D3, current_status_word);
    exec(32'h110F_7000);
    chk("write", 32'h0000_0000, 32'(wr.we));
    exec(32'h010F_6000);
    chk("data", 32'h5000_00D3, wr.data);
    exec(32'hE130_0000);
    chk("unclaimed", 32'h0000_0001, 32'(unc));
  endtask
  task automatic t_mult();
    logic [31:0] rsv [8] = '{32'h0, 32'h1, 32'h2, 32'h7, 32'h8, 32'h1F, 32'h2000_0000, 32'hFFFF_FFFF};
    int mv [8] = '{1, 1, 2, 2, 3, 3, 16, 16};
    setr(8, 32'hFFFF_FFFD);
    setr(11, 32'h1111_1111);
    for (int i = 0; i < 8; i++) begin
      setr(10, rsv[i]);
      exec(32'hE009_0A98);
      chk("latency", 32'(mv[i] + 2), 32'(lat));
      chk("product", 32'hFFFF_FFFD * rsv[i], wr.data);
    end
    setr(10, 32'h1);
    setr(11, 32'h1);
    exec(32'hE039_BA98);
    chk("sum", 32'hFFFF_FFFE, wr.data);
    chk("flags", 32'h9000_0000, current_status_word & 32'hD000_0000);
    setr(11, 32'h3);
    exec(32'hE039_BA98);
    chk("flags", 32'h5000_0000, current_status_word & 32'hD000_0000);
  endtask
  // user mode cannot be left, so this runs last
  task automatic t_user();
    setr(12, 32'h0000_0010);
    exec(32'hE129_F00C);
    chk("status", 32'h0000_0010, current_status_word);
    chk("saved", 32'h0000_0000, saved_status_word);
    setr(13, 32'hF000_00DF);
    exec(32'hE129_F00D);
    chk("status", 32'hF000_0010, current_status_word);
    exec(32'hE14F_E000);
    chk("status", 32'hF000_0010, current_status_word);
  endtask
  initial begin
    srst = 1'b1;
    issue_valid = 1'b0;
    instr = 32'h0000_0000;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_read();
    t_full();
    t_flags();
    t_cond();
    t_mult();
    t_user();
    close_out();
  end
  // 24 instructions of at most 20 cycles each; ample margin
  initial begin
    #200000;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
